// ===== src/fws_host.sv
// host controller running the toggle-bit status check on a parallel flash
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
// How it works
// - host reads twice back to back; unchanged toggle means done
// - toggling with fail bit high: recheck, still toggling means failure
// - interrupted monitoring restarts from the first double read
// - after failure the host issues the reset command
// - host may ignore window bit only if commands under 50 us apart
// - host samples window bit before and after each extra sector erase; this host samples it only at the first read of a poll, with winchk set
// - host reads at program address or an erasing sector address
module fws_host
  import fws_pkg::*;
(
  // system
  input  wire logic        i_clk_sys,
  input  wire logic        i_nrst,
  // software port
  input  wire logic [3:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic      [31:0] o_reg_rdata,
  // flash pins
  output fws_pkg::fws_bus_t o_flash,
  input  wire logic [7:0]  i_flash_dq,
  input  wire logic        i_ready_busy_output
);
  import fws_pkg::*;

  typedef struct packed {
    fws_state_t  st;
    logic [3:0]  cnt;
    logic [1:0]  nrd;
    logic [7:0]  first;
    logic [7:0]  last;
    logic        fail_seen;
    logic        busy;
    logic        done;
    logic        fail;
    logic        win_pre;
    logic        needrst;
    logic        winchk;
    logic        again;
    logic [17:0] addr;
    logic [7:0]  rdata;
    logic [31:0] rd_q;
    fws_bus_t    bus;
  } fws_regs_t;

  fws_regs_t  r_q;
  fws_regs_t  r_d;
  logic [1:0] rst_sync_q;
  logic       rst_n;
  logic [7:0] dq_s1_q;
  logic [7:0] dq_s2_q;
  logic [7:0] dq_s3_q;
  logic [2:0] rb_sync_q;
  logic       ready_lvl_q;
  logic       tgl_changed;

  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // data pins settle during the long read strobe, so three stages suffice
  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dq_s1_q     <= 8'h00;
      dq_s2_q     <= 8'h00;
      dq_s3_q     <= 8'h00;
      rb_sync_q   <= 3'h0;
      ready_lvl_q <= 1'b0;
    end
    else
    begin
      dq_s1_q   <= i_flash_dq;
      dq_s2_q   <= dq_s1_q;
      dq_s3_q   <= dq_s2_q;
      rb_sync_q <= {rb_sync_q[1:0], i_ready_busy_output};
      // open-drain line shared by several parts: high only when all released
      if (rb_sync_q[1] == rb_sync_q[2])
        ready_lvl_q <= rb_sync_q[2];
    end
  end

  assign tgl_changed = r_q.first[BIT_TOGGLE] != dq_s3_q[BIT_TOGGLE];

  always_comb
  begin
    r_d = r_q;
    r_d.rd_q = 32'h0;
    if (i_reg_rd)
    begin
      case (i_reg_addr)
        REG_CTRL:   r_d.rd_q = {30'h0, r_q.winchk, 1'b0};
        REG_STATUS: r_d.rd_q = {26'h0, r_q.needrst, r_q.win_pre, ready_lvl_q,
                                r_q.fail, r_q.done, r_q.busy};
        REG_ADDR:   r_d.rd_q = {14'h0, r_q.addr};
        REG_RDATA:  r_d.rd_q = {24'h0, r_q.rdata};
        default:    r_d.rd_q = 32'h0;
      endcase
    end
    if (i_reg_wr && i_reg_addr == REG_ADDR)
      r_d.addr = i_reg_wdata[17:0];
    case (r_q.st)
      FWS_IDLE: ;
      FWS_RD:
      begin
        if (r_q.cnt != 4'h0)
          r_d.cnt = r_q.cnt - 4'h1;
        else
        begin
          r_d.bus.oe_n = 1'b1;
          r_d.bus.cs_n = 1'b1;
          r_d.cnt = RD_HIGH_CYC;
          r_d.st = FWS_EVAL;
        end
      end
      FWS_EVAL:
      begin
        r_d.st = FWS_GAP;
        r_d.rdata = dq_s3_q;
        if (r_q.nrd == 2'h0)
        begin
          r_d.first = dq_s3_q;
          r_d.nrd = 2'h1;
          if (r_q.winchk)
            r_d.win_pre = dq_s3_q[BIT_WINDOW];
        end
        else if (!tgl_changed)
        begin
          // stopped toggling: finished, possibly after the fail bit rose
          r_d.st = FWS_DONE;
          r_d.done = 1'b1;
        end
        else if (r_q.fail_seen)
        begin
          // still toggling after the fail bit was seen
          r_d.fail = 1'b1;
          r_d.needrst = 1'b1;
          r_d.st = FWS_WR;
          r_d.cnt = RD_LOW_CYC;
          r_d.bus.cs_n = 1'b0;
          r_d.bus.we_n = 1'b0;
          r_d.bus.dq_out = RESET_CMD;
          r_d.bus.dq_oe = 1'b1;
        end
        else
        begin
          r_d.first = dq_s3_q;
          r_d.fail_seen = dq_s3_q[BIT_TMOFAIL];
        end
      end
      FWS_GAP:
      begin
        if (r_q.cnt != 4'h0)
          r_d.cnt = r_q.cnt - 4'h1;
        else
        begin
          r_d.st = FWS_RD;
          r_d.cnt = RD_LOW_CYC;
          r_d.bus.cs_n = 1'b0;
          r_d.bus.oe_n = 1'b0;
        end
      end
      FWS_WR:
      begin
        if (r_q.cnt != 4'h0)
          r_d.cnt = r_q.cnt - 4'h1;
        else
        begin
          r_d.bus.we_n = 1'b1;
          r_d.bus.cs_n = 1'b1;
          r_d.bus.dq_oe = 1'b0;
          r_d.needrst = 1'b0;
          // a restart seen during the reset write resumes polling afterwards
          if (r_q.again)
          begin
            r_d.again = 1'b0;
            r_d.st = FWS_GAP;
            r_d.cnt = RD_HIGH_CYC;
          end
          else
            r_d.st = FWS_DONE;
        end
      end
      FWS_DONE:
      begin
        r_d.busy = 1'b0;
        r_d.st = FWS_IDLE;
      end
      default: r_d.st = FWS_IDLE;
    endcase
    // start is decoded after the sequencer so a restart overrides its choice;
    // a strobe already on the pins still runs to its full width
    if (i_reg_wr && i_reg_addr == REG_CTRL)
    begin
      r_d.winchk = i_reg_wdata[CTRL_WINCHK];
      if (i_reg_wdata[CTRL_START])
      begin
        r_d.nrd = 2'h0;
        r_d.fail_seen = 1'b0;
        r_d.busy = 1'b1;
        r_d.done = 1'b0;
        r_d.fail = 1'b0;
        r_d.needrst = 1'b0;
        r_d.win_pre = 1'b0;
        r_d.again = 1'b0;
        case (r_q.st)
          FWS_RD: ;
          FWS_WR:
          begin
            if (r_q.cnt != 4'h0)
              r_d.again = 1'b1;
            else
            begin
              r_d.st = FWS_GAP;
              r_d.cnt = RD_HIGH_CYC;
            end
          end
          default:
          begin
            r_d.st = FWS_RD;
            r_d.cnt = RD_LOW_CYC;
            r_d.bus.cs_n = 1'b0;
            r_d.bus.oe_n = 1'b0;
            r_d.bus.we_n = 1'b1;
            r_d.bus.dq_oe = 1'b0;
            r_d.bus.addr = r_d.addr;
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_q <= '0;
      r_q.st <= FWS_IDLE;
      r_q.bus.cs_n <= 1'b1;
      r_q.bus.oe_n <= 1'b1;
      r_q.bus.we_n <= 1'b1;
    end
    else
      r_q <= r_d;
  end

  assign o_flash = r_q.bus;
  assign o_reg_rdata = r_q.rd_q;
endmodule // fws_host

// ===== shared/fws_pkg.sv
// package for the flash write-status host controller
package fws_pkg;
  // control register offsets (word addresses on the software port)
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_ADDR   = 4'h2;
  localparam logic [3:0] REG_RDATA  = 4'h3;
  // control register fields
  localparam int CTRL_START  = 0;
  localparam int CTRL_WINCHK = 1;
  // status register fields
  localparam int ST_BUSY     = 0;
  localparam int ST_DONE     = 1;
  localparam int ST_FAIL     = 2;
  localparam int ST_READY    = 3;
  localparam int ST_WINDOW   = 4;
  localparam int ST_NEEDRST  = 5;
  // data bus bit positions of the status bits
  localparam int BIT_POLL    = 7;
  localparam int BIT_TOGGLE  = 6;
  localparam int BIT_TMOFAIL = 5;
  localparam int BIT_WINDOW  = 3;
  localparam int BIT_SECTGL  = 2;
  // bus timing: counter loads for strobe width (plus one clock) and read recovery (plus two clocks)
  localparam logic [3:0] RD_LOW_CYC  = 4'h3;
  localparam logic [3:0] RD_HIGH_CYC = 4'h2;
  localparam logic [7:0] RESET_CMD   = 8'hF0;

  typedef enum logic [2:0] {
    FWS_IDLE  = 3'b000,
    FWS_RD    = 3'b001,
    FWS_GAP   = 3'b011,
    FWS_EVAL  = 3'b010,
    FWS_WR    = 3'b110,
    FWS_DONE  = 3'b111
  } fws_state_t;

  typedef struct packed {
    logic        cs_n;
    logic        oe_n;
    logic        we_n;
    logic [17:0] addr;
    logic [7:0]  dq_out;
    logic        dq_oe;
  } fws_bus_t;
endpackage

// ===== verification/fws_props.sv
// checker watching the flash status host ports
`timescale 1ns/1ps
module fws_props
  import fws_pkg::*;
(
  input wire logic        i_clk_sys,
  input wire logic        i_nrst,
  input wire logic [3:0]  i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [31:0] o_reg_rdata,
  input fws_pkg::fws_bus_t o_flash,
  input wire logic [7:0]  i_flash_dq,
  input wire logic        i_ready_busy_output
);
  logic [17:0] addr_q;
  always_ff @(posedge i_clk_sys or negedge i_nrst)
    if (!i_nrst)
      addr_q <= 18'h00000;
    else if (i_reg_wr && i_reg_addr == REG_ADDR)
      addr_q <= i_reg_wdata[17:0];
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  a_read_width: assert property ($fell(o_flash.oe_n) |->
    (!o_flash.oe_n)[*4] ##1 o_flash.oe_n) else $error("read strobe width wrong");
  a_start_reads: assert property (i_reg_wr && i_reg_addr == REG_CTRL
    && i_reg_wdata[CTRL_START] && o_flash.oe_n && o_flash.we_n |-> ##1 !o_flash.oe_n)
    else $error("start without read");
  a_read_addr: assert property (!o_flash.oe_n |-> o_flash.addr == addr_q)
    else $error("read address differs");
  a_cs_read: assert property (!o_flash.oe_n |-> !o_flash.cs_n)
    else $error("read without select");
  a_no_clash: assert property (o_flash.dq_oe |-> o_flash.oe_n)
    else $error("drive during read");
  a_reset_cmd: assert property ($fell(o_flash.we_n) |->
    o_flash.dq_oe && o_flash.dq_out == RESET_CMD) else $error("bad command byte");
  a_write_width: assert property ($fell(o_flash.we_n) |->
    (!o_flash.we_n)[*4] ##1 o_flash.we_n) else $error("write strobe width wrong");
  a_rdata_idle: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0)
    else $error("read data outside slot");
  c_start: cover property (i_reg_wr && i_reg_addr == REG_CTRL);
  c_read: cover property ($fell(o_flash.oe_n));
  c_cmd: cover property ($fell(o_flash.we_n));
endmodule // fws_props
bind fws_host fws_props u_props (.i_clk_sys, .i_nrst, .i_reg_addr, .i_reg_wdata,
  .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_flash, .i_flash_dq, .i_ready_busy_output);

// ===== verification/fws_flash_model.sv
// behavioural flash answering status reads
`timescale 1ns/1ps
module fws_flash_model
  import fws_pkg::*;
(
  input  fws_pkg::fws_bus_t i_bus,
  output logic [7:0]        o_dq,
  output logic              o_rb_drive
);
  int         cnt_q = 0;
  logic       fail_q = 1'b0;
  logic       tog_q = 1'b0;
  logic       win_q = 1'b0;
  logic       busy;
  logic [7:0] v;
  assign busy = (cnt_q > 0) || fail_q;
  // erase-style status: poll bit low while busy, sector toggle follows toggle bit
  assign v = {!busy, tog_q, fail_q, 1'b0, win_q, tog_q, 2'h0};
  // released bus shows the inverse so a stale byte never passes as status
  assign o_dq = (!i_bus.cs_n && !i_bus.oe_n) ? v : ~v;
  assign o_rb_drive = busy;
  task automatic op(input int n, input logic f, input logic w);
    cnt_q = n;
    fail_q = f;
    win_q = w;
  endtask
  always @(posedge i_bus.oe_n)
    if (busy)
    begin
      tog_q <= ~tog_q;
      if (cnt_q > 0)
        cnt_q <= cnt_q - 1;
    end
  always @(posedge i_bus.we_n)
    if (i_bus.dq_out == RESET_CMD)
      fail_q <= 1'b0;
endmodule // fws_flash_model

// ===== verification/tb_top.sv
// testbench for the flash status host
`timescale 1ns/1ps
module tb_top;
  import fws_pkg::*;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [3:0]  ra = 4'h0;
  logic [31:0] wd = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic [31:0] st;
  logic [31:0] rv;
  fws_bus_t    bus;
  logic [7:0]  dq;
  logic        rb_drive;
  logic        tog = 1'b0;
  logic        hung = 1'b0;
  logic        wv = 1'b0;
  logic [31:0] addr_v = 32'h0;
  int          mismatches = 0;
  int          tests_run = 0;
  integer      seed = 32'hc825a7bc;
  always #20 clk = ~clk;
  fws_host uut (.i_clk_sys(clk), .i_nrst(nrst), .i_reg_addr(ra), .i_reg_wdata(wd),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_flash(bus),
    .i_flash_dq(dq), .i_ready_busy_output(!rb_drive));
  fws_flash_model flash (.i_bus(bus), .o_dq(dq), .o_rb_drive(rb_drive));
  task automatic conclude();
    $display("tests_run %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    ra <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    ra <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  // byte of a finished erase: poll bit true, window bit as the flash holds it
  function automatic logic [31:0] exp_byte(input logic t, input logic w);
    return {24'h0, 1'b1, t, 2'h0, w, t, 2'h0};
  endfunction
  function automatic logic [31:0] exp_status(input logic f, input logic w);
    return f ? 32'h4 : {26'h0, 1'b0, w, 4'hA};
  endfunction
  task automatic run(input int n, input logic f, input logic again, input logic chk);
    int k;
    wv = 1'($random(seed));
    flash.op(n, f, wv);
    wr_reg(REG_CTRL, {30'h0, chk, 1'b1});
    if (again)
    begin
      repeat (5) @(posedge clk);
      wr_reg(REG_CTRL, {30'h0, chk, 1'b1});
    end
    k = 0;
    st = 32'h1;
    while (st[ST_BUSY] !== 1'b0 && k < 100)
    begin
      rd_reg(REG_STATUS, st);
      k++;
    end
    if (st[ST_BUSY] !== 1'b0)
    begin
      mismatches++;
      hung = 1'b1;
    end
    else
    begin
      check("status", st & (f ? 32'h37 : 32'h3F), exp_status(f, chk & wv));
      rd_reg(REG_CTRL, rv);
      check("control", rv, {30'h0, chk, 1'b0});
      if (f)
        check("ready line", rb_drive, 1'b0);
      else
      begin
        tog = tog ^ n[0];
        rd_reg(REG_RDATA, rv);
        check("last byte", rv, exp_byte(tog, wv));
      end
    end
    $display("case n=%0d fail=%0b restart=%0b done", n, f, again);
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    addr_v = $random(seed) & 32'h3FFFF;
    wr_reg(REG_ADDR, addr_v);
    rd_reg(REG_ADDR, rv);
    check("address", rv, addr_v);
    for (int i = 0; i < 6 && !hung; i++)
      run(i < 2 ? i : $random(seed) & 7, 1'b0, 1'b0, 1'(i));
    if (!hung)
      run(5, 1'b0, 1'b1, 1'b1);
    rd_reg(4'h9, rv);
    check("unmapped", rv, 32'h0);
    if (!hung)
      run(0, 1'b1, 1'b0, 1'b0);
    conclude();
  end
endmodule // tb_top
